/* cdu_assertions.sv */
// checker: port-level properties of the current dac update control
`timescale 1ns/1ps
module cdu_assertions (
  // clock and reset
  input wire logic                    clock,
  input wire logic                    rst_n,
  // register port
  input wire logic [7:0]              reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  // update sources
  input wire logic [3:0]              timer_overflow,
  input wire logic                    conversion_start_pin,
  // converter side
  input wire cdu_pkg::cdu_analog_type analog_out,
  input wire logic                    update_pulse
);
  import cdu_pkg::*;
  // shadows of source field and data word, rebuilt from bus writes only
  logic [2:0] src_r;
  logic [9:0] word_r;
  wire wr_high = reg_wr && reg_addr == CDU_ADDR_DATA_HIGH;
  wire tmr = src_r < 3'h4 && timer_overflow[src_r[1:0]];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) src_r <= 3'h7;
    else if (reg_wr && reg_addr == CDU_ADDR_CONTROL) src_r <= reg_wdata[6:4];
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) word_r <= 10'h000;
    else if (wr_high) word_r[9:2] <= reg_wdata;
    else if (reg_wr && reg_addr == CDU_ADDR_DATA_LOW) word_r[1:0] <= reg_wdata[7:6];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_ctl_rd; reg_rd && reg_addr == CDU_ADDR_CONTROL |=> reg_rdata[3:2] == 2'h0; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control unused bits not zero");
  property p_low_rd; reg_rd && reg_addr == CDU_ADDR_DATA_LOW |=> reg_rdata[5:0] == 6'h00; endproperty
  a_low_rd: assert property (p_low_rd) else $error("low data unused bits not zero");
  property p_wr_high;
    src_r == 3'h7 && wr_high |=> update_pulse && analog_out.code == word_r;
  endproperty
  a_wr_high: assert property (p_wr_high) else $error("high write did not update");
  property p_hold_high; src_r == 3'h7 && !wr_high |=> $stable(analog_out.code); endproperty
  a_hold_high: assert property (p_hold_high) else $error("output moved without high write");
  property p_timer; tmr |=> update_pulse && analog_out.code == word_r; endproperty
  a_timer: assert property (p_timer) else $error("timer overflow update wrong");
  property p_timer_hold; src_r < 3'h4 && !tmr |=> !update_pulse; endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("update without chosen overflow");
  sequence s_pin_still;
    (src_r[2] && src_r != 3'h7 && $stable(conversion_start_pin))[*6];
  endsequence
  property p_pin_quiet; s_pin_still |=> !update_pulse; endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("update without pin edge");
  property p_enable; reg_wr && reg_addr == CDU_ADDR_CONTROL |=> analog_out.enable == $past(reg_wdata[7]); endproperty
  a_enable: assert property (p_enable) else $error("enable does not follow bit 7");
  property p_range;
    reg_wr && reg_addr == CDU_ADDR_CONTROL |=> analog_out.range == ($past(reg_wdata[1]) ? CDU_RANGE_2MA :
      ($past(reg_wdata[0]) ? CDU_RANGE_1MA : CDU_RANGE_0P5MA));
  endproperty
  a_range: assert property (p_range) else $error("range decode wrong");
  c_timer: cover property (tmr);
  c_any_edge: cover property (src_r == 3'h6 && update_pulse);
  c_high: cover property (src_r == 3'h7 && wr_high);
endmodule // cdu_assertions

bind cdu_top cdu_assertions u_chk (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_overflow(timer_overflow),
  .conversion_start_pin(conversion_start_pin), .analog_out(analog_out), .update_pulse(update_pulse));

/* cdu_edge_detect.sv */
// module: pin synchroniser and edge detector for the conversion-start pin
`timescale 1ns/1ps

module cdu_edge_detect (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // pin
  input  wire logic pin_in,
  // edge pulses
  output logic      rise_pulse,
  output logic      fall_pulse
);
  import cdu_pkg::*;

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic level_r;

  // ---------------------------------------------------------------
  // synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // ---------------------------------------------------------------
  // filtered level; a change counts once stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= 1'b0;
    end else if (sync2_r == sync3_r) begin
      level_r <= sync3_r;
    end
  end

  // one pulse per qualifying edge
  assign rise_pulse = (sync2_r == sync3_r) && sync3_r && !level_r;
  assign fall_pulse = (sync2_r == sync3_r) && !sync3_r && level_r;

endmodule // cdu_edge_detect

/* cdu_pkg.sv */
// package: register map, field layout, reset values and update sources of the current dac control
package cdu_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CDU_ADDR_DATA_LOW  = 8'h96;
  localparam logic [7:0] CDU_ADDR_DATA_HIGH = 8'h97;
  localparam logic [7:0] CDU_ADDR_CONTROL   = 8'hB9;

  // ---------------------------------------------------------------
  // field positions and masks
  // ---------------------------------------------------------------
  localparam int         CDU_CTL_ENABLE_POS  = 7;
  localparam int         CDU_CTL_SOURCE_LSB  = 4;
  localparam int         CDU_CTL_RANGE_LSB   = 0;
  localparam logic [7:0] CDU_CTL_WRITE_MASK  = 8'hF3;
  localparam logic [7:0] CDU_LOW_WRITE_MASK  = 8'hC0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CDU_RST_DATA_LOW  = 8'h00;
  localparam logic [7:0] CDU_RST_DATA_HIGH = 8'h00;
  localparam logic [7:0] CDU_RST_CONTROL   = 8'h72;
  localparam logic [9:0] CDU_RST_LATCH     = 10'h000;
  localparam logic [7:0] CDU_RST_READ      = 8'h00;

  // ---------------------------------------------------------------
  // update sources and full-scale ranges
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CDU_SRC_TIMER0  = 3'h0,
    CDU_SRC_TIMER1  = 3'h1,
    CDU_SRC_TIMER2  = 3'h2,
    CDU_SRC_TIMER3  = 3'h3,
    CDU_SRC_RISE    = 3'h4,
    CDU_SRC_FALL    = 3'h5,
    CDU_SRC_ANY     = 3'h6,
    CDU_SRC_WRITE_H = 3'h7
  } cdu_source_type;

  typedef enum logic [1:0] {
    CDU_RANGE_0P5MA = 2'h0,
    CDU_RANGE_1MA   = 2'h1,
    CDU_RANGE_2MA   = 2'h2
  } cdu_range_type;

  // register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cdu_bus_req_type;

  // analog side settings
  typedef struct packed {
    logic          enable;
    cdu_range_type range;
    logic [9:0]    code;
  } cdu_analog_type;

endpackage

/* cdu_top.sv */
// module: register file and output update scheduling of the current dac
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps

module cdu_top (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [7:0]                 reg_rdata,
  // update event sources
  input  wire logic [3:0]            timer_overflow,
  input  wire logic                  conversion_start_pin,
  // converter side
  output cdu_pkg::cdu_analog_type    analog_out,
  output logic                       update_pulse
);
  import cdu_pkg::*;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  cdu_bus_req_type req;
  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  logic wr_low;
  logic wr_high;
  logic wr_ctl;
  assign wr_low  = req.wr && hit(req.addr, CDU_ADDR_DATA_LOW);
  assign wr_high = req.wr && hit(req.addr, CDU_ADDR_DATA_HIGH);
  assign wr_ctl  = req.wr && hit(req.addr, CDU_ADDR_CONTROL);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] data_low_r;
  logic [7:0] data_high_r;
  logic [7:0] control_r;
  logic [9:0] latch_r;
  logic [7:0] rdata_r;
  logic       update_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_low_r <= CDU_RST_DATA_LOW;
    end else if (wr_low) begin
      data_low_r <= req.wdata & CDU_LOW_WRITE_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_high_r <= CDU_RST_DATA_HIGH;
    end else if (wr_high) begin
      data_high_r <= req.wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      control_r <= CDU_RST_CONTROL;
    end else if (wr_ctl) begin
      control_r <= req.wdata & CDU_CTL_WRITE_MASK;
    end
  end

  cdu_source_type source;
  assign source = cdu_source_type'(control_r[CDU_CTL_SOURCE_LSB +: 3]);

  // ---------------------------------------------------------------
  // start pin edges
  // ---------------------------------------------------------------
  logic pin_rise;
  logic pin_fall;

  cdu_edge_detect u_edge (
    .clock      (clock),
    .rst_n      (rst_n),
    .pin_in     (conversion_start_pin),
    .rise_pulse (pin_rise),
    .fall_pulse (pin_fall)
  );

  // ---------------------------------------------------------------
  // update event selection
  // ---------------------------------------------------------------
  logic event_now;
  always_comb begin
    event_now = 1'b0;
    case (source)
      CDU_SRC_TIMER0:  event_now = timer_overflow[0];
      CDU_SRC_TIMER1:  event_now = timer_overflow[1];
      CDU_SRC_TIMER2:  event_now = timer_overflow[2];
      CDU_SRC_TIMER3:  event_now = timer_overflow[3];
      CDU_SRC_RISE:    event_now = pin_rise;
      CDU_SRC_FALL:    event_now = pin_fall;
      CDU_SRC_ANY:     event_now = pin_rise || pin_fall;
      CDU_SRC_WRITE_H: event_now = wr_high;
      default:         event_now = 1'b0;
    endcase
  end

  // a high-byte write in the same cycle as the event is taken along,
  // so the latch never misses the byte that software just wrote
  logic [7:0] high_now;
  logic [7:0] low_now;
  assign high_now = wr_high ? req.wdata : data_high_r;
  assign low_now  = wr_low ? (req.wdata & CDU_LOW_WRITE_MASK) : data_low_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= CDU_RST_LATCH;
    end else if (event_now) begin
      latch_r <= {high_now, low_now[7:6]};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      update_r <= 1'b0;
    end else begin
      update_r <= event_now;
    end
  end

  // ---------------------------------------------------------------
  // read port: data one cycle after the strobe, zero otherwise
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= CDU_RST_READ;
    end else if (req.rd && hit(req.addr, CDU_ADDR_DATA_LOW)) begin
      rdata_r <= data_low_r;
    end else if (req.rd && hit(req.addr, CDU_ADDR_DATA_HIGH)) begin
      rdata_r <= data_high_r;
    end else if (req.rd && hit(req.addr, CDU_ADDR_CONTROL)) begin
      rdata_r <= control_r;
    end else begin
      rdata_r <= CDU_RST_READ;
    end
  end

  assign reg_rdata = rdata_r;

  // ---------------------------------------------------------------
  // analog settings
  // ---------------------------------------------------------------
  cdu_range_type range_sel;
  always_comb begin
    range_sel = CDU_RANGE_2MA;
    case (control_r[CDU_CTL_RANGE_LSB +: 2])
      2'h0:    range_sel = CDU_RANGE_0P5MA;
      2'h1:    range_sel = CDU_RANGE_1MA;
      default: range_sel = CDU_RANGE_2MA;
    endcase
  end

  assign analog_out.enable = control_r[CDU_CTL_ENABLE_POS];
  assign analog_out.range  = range_sel;
  assign analog_out.code   = latch_r;
  assign update_pulse      = update_r;

endmodule // cdu_top

/* tb_top.sv */
// testbench: registers, update sources and range of the current dac control
`timescale 1ns/1ps
module tb_top;
  import cdu_pkg::*;
  logic           clock, rst_n, reg_wr, reg_rd, conversion_start_pin, update_pulse;
  logic [7:0]     reg_addr, reg_wdata, reg_rdata, h, l;
  logic [3:0]     timer_overflow;
  cdu_analog_type analog_out, exp_a;
  logic [15:0]    lfsr_r;
  logic [9:0]     w;
  int             miscompares, samples_checked, cyc;
  cdu_top dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_overflow(timer_overflow),
    .conversion_start_pin(conversion_start_pin), .analog_out(analog_out), .update_pulse(update_pulse));
  // ----------------------------------------
  // expectations and bus tasks
  // ----------------------------------------
  function automatic cdu_range_type exp_range(input logic [1:0] m);
    return m[1] ? CDU_RANGE_2MA : (m[0] ? CDU_RANGE_1MA : CDU_RANGE_0P5MA);
  endfunction
  task automatic rnd(output logic [7:0] v);
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    v = lfsr_r[7:0];
  endtask
  task automatic chk_reg(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t read %h expected %h", $time, g, e);
    end
  endtask
  // settle past the launching edge before looking at the registered outputs
  task automatic chk_out(input cdu_analog_type e);
    #1;
    samples_checked++;
    if (analog_out !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t analog %h expected %h", $time, analog_out, e);
    end
  endtask
  // called right after chk_out, inside the cycle after the event edge
  task automatic chk_pulse(input logic e);
    samples_checked++;
    if (update_pulse !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t update pulse %b expected %b", $time, update_pulse, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk_reg(reg_rdata, e);
  endtask
  // low byte first so the whole word is in place before any update
  task automatic load(output logic [9:0] v);
    rnd(h);
    rnd(l);
    wr(CDU_ADDR_DATA_LOW, l);
    wr(CDU_ADDR_DATA_HIGH, h);
    v = {h, l[7:6]};
  endtask
  task automatic tick(input logic [3:0] b);
    @(posedge clock);
    timer_overflow <= b;
    @(posedge clock);
    timer_overflow <= 4'h0;
    repeat (2) @(posedge clock);
  endtask
  // pin held long enough to pass the synchroniser and its sampling jitter
  task automatic pin(input logic v);
    @(posedge clock);
    conversion_start_pin <= v;
    repeat (8) @(posedge clock);
  endtask
  task automatic complete_run;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, timeout and sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, conversion_start_pin} = 4'h0;
    {reg_addr, reg_wdata, timer_overflow} = 20'h00000;
    lfsr_r = 16'h5A43;
    exp_a = '{1'b0, CDU_RANGE_2MA, 10'h000};
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk(CDU_ADDR_CONTROL, CDU_RST_CONTROL);
    rd_chk(CDU_ADDR_DATA_HIGH, CDU_RST_DATA_HIGH);
    rd_chk(8'h55, 8'h00);
    wr(CDU_ADDR_DATA_LOW, 8'hFF);
    rd_chk(CDU_ADDR_DATA_LOW, 8'hC0);
    chk_out(exp_a);
    for (int i = 0; i < 4; i++) begin
      wr(CDU_ADDR_CONTROL, {i[0], 3'h7, 2'h3, i[1:0]});
      rd_chk(CDU_ADDR_CONTROL, {i[0], 3'h7, 2'h0, i[1:0]});
      exp_a.enable = i[0];
      exp_a.range = exp_range(i[1:0]);
      chk_out(exp_a);
    end
    for (int k = 0; k < 4; k++) begin
      rnd(h);
      rnd(l);
      wr(CDU_ADDR_DATA_LOW, l);
      chk_out(exp_a);
      chk_pulse(1'b0);
      wr(CDU_ADDR_DATA_HIGH, h);
      exp_a.code = {h, l[7:6]};
      chk_out(exp_a);
      chk_pulse(1'b1);
    end
    for (int s = 0; s < 4; s++) begin
      wr(CDU_ADDR_CONTROL, {2'h2, s[1:0], 4'h3});
      load(w);
      tick(4'hF ^ (4'h1 << s));
      chk_out(exp_a);
      tick(4'h1 << s);
      exp_a.code = w;
      chk_out(exp_a);
    end
    for (int m = 4; m < 7; m++) begin
      wr(CDU_ADDR_CONTROL, {1'b1, m[2:0], 4'h3});
      load(w);
      pin(1'b1);
      if (m != 5) exp_a.code = w;
      chk_out(exp_a);
      load(w);
      pin(1'b0);
      if (m != 4) exp_a.code = w;
      chk_out(exp_a);
    end
    complete_run;
  end
endmodule // tb_top
